//--- core/srcaf_device.sv
// codec end: window control, clock resync, exit calibration and sample coding
`timescale 1ns/100ps
`include "srcaf_map.svh"
module srcaf_device #(
   parameter int RESYNC_FIRST_CYC = `SRCAF_RESYNC_FIRST_CYC, // first resync after reset
   parameter int RESYNC_LATER_CYC = `SRCAF_RESYNC_LATER_CYC  // later rate changes
) (
   input  wire logic             clock,           // 25 MHz clock
   input  wire logic             rst_b,           // asynchronous reset, active low
   input  wire logic             ce,              // clock enable
   srcaf_link_if.device          link,            // port towards the host
   input  wire logic [15:0]      adcSample,       // linear capture sample
   output logic [15:0]           dacSample,       // playback sample to converter
   output logic                  outMuted,        // converter outputs muted
   output logic                  firstCrystalEn,  // first_crystal_input in use
   output logic                  secondCrystalEn, // second_crystal_input in use
   output logic [23:0]           serialClockHz,   // serial clock rate in use
   output srcaf_pkg::srcaf_fmt_t activeFormat     // sample coding in use
);
   import srcaf_pkg::*;

   srcaf_dev_st_t           state;
   srcaf_dev_st_t           next_state;
   logic                    mode_change_window_bit;
   logic                    calOnExit;
   logic [2:0]              divSel;
   logic                    srcSel;
   logic [2:0]              divAct;
   logic                    srcAct;
   logic                    changeReq;
   logic                    resyncPending;
   logic                    firstDone;
   logic [`SRCAF_TMO_W-1:0] tmoCnt;
   logic [9:0]              smpCnt;
   logic [9:0]              period;
   logic                    sampleIdx;
   logic                    calBusy;
   logic [8:0]              calLeft;
   logic                    frameSync;
   logic                    sampleTick;
   logic [15:0]             capData;
   logic                    accept;
   logic                    fmtWrOk;
   logic                    mceExit;
   logic                    tick;
   logic                    frameStart;
   logic                    lastSample;
   logic                    enterResync;

   // mu-law: bias, find segment, keep four mantissa bits, invert
   function automatic logic [7:0] encMu(input logic [15:0] x);
      logic [15:0] mag;
      logic [2:0]  ex;
      logic [3:0]  man;
      mag = x[15] ? (~x + 16'h0001) : x;
      ex  = 3'h0;
      if (mag > `SRCAF_MU_CLIP) begin
         mag = `SRCAF_MU_CLIP;
      end
      mag = mag + `SRCAF_MU_BIAS;
      for (int i = 1; i < 8; i++) begin
         if (mag[i+7]) begin
            ex = 3'(i);
         end
      end
      // widen before adding: a 3-bit sum would wrap for the top segments
      man = 4'(mag >> ({1'b0, ex} + 4'h3));
      return ~{x[15], ex, man};
   endfunction

   // A-law on the 13-bit magnitude, even bits toggled by the mask
   function automatic logic [7:0] encA(input logic [15:0] x);
      logic [12:0] m;
      logic [2:0]  seg;
      logic [3:0]  man;
      m   = x[15] ? ~x[15:3] : x[15:3];
      seg = 3'h0;
      for (int i = 1; i < 8; i++) begin
         if (m[i+4]) begin
            seg = 3'(i);
         end
      end
      man = (seg < 3'h2) ? m[4:1] : 4'(m >> seg);
      return {1'b0, seg, man} ^ (x[15] ? `SRCAF_A_NEG_MASK : `SRCAF_A_POS_MASK);
   endfunction

   // capture coding; 8-bit results sit in the low byte
   function automatic logic [15:0] encode(input logic [15:0] x, input srcaf_fmt_t f);
      logic [15:0] r;
      r = 16'h0000;
      unique case (f)
         FMT_S16: r = x;
         FMT_U8:  r = {8'h00, ~x[15], x[14:8]};
         FMT_MU:  r = {8'h00, encMu(x)};
         FMT_A:   r = {8'h00, encA(x)};
      endcase
      return r;
   endfunction

   // words offered while the port is down are simply not taken
   assign accept      = link.ctrlValid & ~resyncPending;
   assign fmtWrOk     = accept & link.ctrlMce & link.ctrlFmtWr;
   assign mceExit     = accept & ~link.ctrlMce & mode_change_window_bit;
   assign period      = 10'(`SRCAF_SAMPLE_BASE_CYC * ({7'h00, divAct} + 10'h001));
   assign tick        = (state != DS_RESYNC) && (smpCnt == period - 10'h001);
   assign frameStart  = tick & sampleIdx;
   assign lastSample  = tick & ~sampleIdx;
   assign enterResync = (state == DS_NEXT) & lastSample;

   // window bit follows every accepted word
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         mode_change_window_bit <= 1'b0;
      end else if (ce && accept) begin
         mode_change_window_bit <= link.ctrlMce;
      end
   end

   // format, divider and source move only inside the window
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         divSel       <= `SRCAF_DIV_RST;
         srcSel       <= `SRCAF_SRC_FIRST;
         activeFormat <= FMT_S16;
         calOnExit    <= `SRCAF_CAL_RST;
      end else if (ce && fmtWrOk) begin
         divSel       <= link.ctrlDiv;
         srcSel       <= link.ctrlSrc;
         activeFormat <= link.ctrlFmt;
         calOnExit    <= link.ctrlCalExit;
      end
   end

   // a new clock setting waits for the resync; a fresh one during wait wins
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         changeReq <= 1'b0;
      end else if (ce) begin
         if (fmtWrOk && ((link.ctrlDiv != divSel) || (link.ctrlSrc != srcSel))) begin
            changeReq <= 1'b1;
         end else if (enterResync) begin
            changeReq <= 1'b0;
         end
      end
   end

   // resync sequence
   always_comb begin
      next_state = state;
      unique case (state)
         DS_RUN:    if (changeReq) next_state = DS_ARMED;
         DS_ARMED:  if (frameStart) next_state = DS_NEXT;
         DS_NEXT:   if (lastSample) next_state = DS_RESYNC;
         DS_RESYNC: if (tmoCnt == `SRCAF_TMO_W'(1)) next_state = DS_WAITFS;
         DS_WAITFS: if (frameStart) next_state = DS_RUN;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= DS_RUN;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // timeout: long only for the first change after reset
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tmoCnt    <= '0;
         firstDone <= 1'b0;
      end else if (ce) begin
         if (enterResync) begin
            tmoCnt    <= firstDone ? `SRCAF_TMO_W'(RESYNC_LATER_CYC) : `SRCAF_TMO_W'(RESYNC_FIRST_CYC);
            firstDone <= 1'b1;
         end else if (state == DS_RESYNC) begin
            tmoCnt <= tmoCnt - `SRCAF_TMO_W'(1);
         end
      end
   end

   // new clock takes over as the port goes down
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         divAct <= `SRCAF_DIV_RST;
         srcAct <= `SRCAF_SRC_FIRST;
      end else if (ce && enterResync) begin
         divAct <= divSel;
         srcAct <= srcSel;
      end
   end

   // resync flag: up at last sample, down at first frame sync after timeout
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         resyncPending <= 1'b0;
      end else if (ce) begin
         if (enterResync) begin
            resyncPending <= 1'b1;
         end else if ((state == DS_WAITFS) && frameStart) begin
            resyncPending <= 1'b0;
         end
      end
   end

   // sample timer stops during resync and restarts on a frame boundary
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         smpCnt    <= 10'h000;
         sampleIdx <= 1'b1;
      end else if (ce) begin
         if (state == DS_RESYNC) begin
            smpCnt    <= 10'h000;
            sampleIdx <= 1'b1;
         end else if (tick) begin
            smpCnt    <= 10'h000;
            sampleIdx <= ~sampleIdx;
         end else begin
            smpCnt <= smpCnt + 10'h001;
         end
      end
   end

   // exit from the window: calibrate or mute, counted in samples
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         calBusy <= 1'b0;
         calLeft <= 9'h000;
      end else if (ce) begin
         if (mceExit) begin
            calBusy <= 1'b1;
            calLeft <= calOnExit ? `SRCAF_CAL_SAMPLES : `SRCAF_MUTE_SAMPLES;
         end else if (calBusy && tick) begin
            calLeft <= calLeft - 9'h001;
            if (calLeft == 9'h001) begin
               calBusy <= 1'b0;
            end
         end
      end
   end

   // sample path; muting forces linear zero, which is mid-scale
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         frameSync  <= 1'b0;
         sampleTick <= 1'b0;
         capData    <= 16'h0000;
         dacSample  <= 16'h0000;
         outMuted   <= 1'b0;
      end else if (ce) begin
         frameSync  <= frameStart;
         sampleTick <= tick;
         outMuted   <= calBusy | link.hostMute;
         if (tick) begin
            capData   <= encode(adcSample, activeFormat);
            dacSample <= (calBusy | link.hostMute) ? 16'h0000 : link.playData;
         end
      end
   end

   // crystal selection follows the active source
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         firstCrystalEn  <= 1'b1;
         secondCrystalEn <= 1'b0;
         serialClockHz   <= `SRCAF_FIRST_SCLK_HZ;
      end else if (ce) begin
         firstCrystalEn  <= ~srcAct;
         secondCrystalEn <= srcAct;
         serialClockHz   <= srcAct ? `SRCAF_SECOND_SCLK_HZ : `SRCAF_FIRST_SCLK_HZ;
      end
   end

   assign link.portReady     = ~resyncPending;
   assign link.frameSync     = frameSync;
   assign link.sampleTick    = sampleTick;
   assign link.resyncPending = resyncPending;
   assign link.calBusy       = calBusy;
   assign link.capData       = capData;
endmodule

//--- core/srcaf_host.sv
// host end: runs the rate-change sequence on order from APB registers
`timescale 1ns/100ps
`include "srcaf_map.svh"
module srcaf_host (
   input  wire logic        clock,      // 25 MHz clock
   input  wire logic        rst_b,      // asynchronous reset, active low
   input  wire logic        ce,         // clock enable
   input  wire logic        psel,       // APB select
   input  wire logic        penable,    // APB enable
   input  wire logic        pwrite,     // APB write
   input  wire logic [7:0]  paddr,      // APB byte address
   input  wire logic [31:0] pwdata,     // APB write data
   output logic [31:0]      prdata,     // APB read data
   output logic             pready,     // APB ready
   output logic             pslverr,    // APB error on unmapped address
   output logic             irq,        // level interrupt
   srcaf_link_if.host       link,       // port towards the codec
   input  wire logic [15:0] playSample  // playback sample source
);
   import srcaf_pkg::*;

   srcaf_host_st_t state;
   srcaf_host_st_t next_state;
   logic [2:0]     cfgDiv;
   logic           cfgSrc;
   srcaf_fmt_t     cfgFmt;
   logic           cfgCal;
   logic [2:0]     curDiv;
   logic           curSrc;
   logic [1:0]     evStatus;
   logic [1:0]     evMask;
   logic [1:0]     evSet;
   logic [31:0]    rdMux;
   logic           access;
   logic           hit;
   logic           go;
   logic           sent;
   logic           mceWord;
   logic           muteReg;
   logic [15:0]    playReg;

   assign access  = psel & penable;
   assign hit     = (paddr == `SRCAF_A_CTRL) || (paddr == `SRCAF_A_STATUS)
                    || (paddr == `SRCAF_A_MASK) || (paddr == `SRCAF_A_STATE);
   assign pready  = 1'b1;
   assign pslverr = access & ~hit;
   assign go      = ce & access & pwrite & (paddr == `SRCAF_A_CTRL) & pwdata[`SRCAF_CTRL_GO_BIT] & (state == HS_IDLE);
   assign sent    = link.portReady & ((state == HS_ENTER) | (state == HS_EXIT));

   // sequence: enter window, wait resync if divider or source changes, leave window, wait calibration
   always_comb begin
      next_state = state;
      unique case (state)
         HS_IDLE:   if (go) next_state = HS_ENTER;
         HS_ENTER:  if (sent) next_state = ((cfgDiv != curDiv) || (cfgSrc != curSrc)) ? HS_FLAG : HS_EXIT;
         HS_FLAG:   if (link.resyncPending) next_state = HS_PORT;
         HS_PORT:   if (link.portReady) next_state = HS_EXIT;
         HS_EXIT:   if (sent) next_state = HS_BUSYHI;
         HS_BUSYHI: if (link.calBusy) next_state = HS_BUSYLO;
         HS_BUSYLO: if (!link.calBusy) next_state = HS_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state   <= HS_IDLE;
         mceWord <= 1'b0;
         muteReg <= 1'b0;
      end else if (ce) begin
         state   <= next_state;
         mceWord <= (next_state == HS_ENTER);
         muteReg <= (next_state != HS_IDLE);
      end
   end

   // host's record of the codec clock, to skip a needless resync
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         curDiv <= `SRCAF_DIV_RST;
         curSrc <= `SRCAF_SRC_FIRST;
      end else if (ce && sent && (state == HS_ENTER)) begin
         curDiv <= cfgDiv;
         curSrc <= cfgSrc;
      end
   end

   // order fields are frozen while a sequence runs
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cfgDiv <= `SRCAF_DIV_RST;
         cfgSrc <= `SRCAF_SRC_FIRST;
         cfgFmt <= FMT_S16;
         cfgCal <= `SRCAF_CAL_RST;
         evMask <= 2'h0;
      end else if (ce && access && pwrite) begin
         if ((paddr == `SRCAF_A_CTRL) && (state == HS_IDLE)) begin
            cfgDiv <= pwdata[`SRCAF_CTRL_DIV_LSB +: 3];
            cfgSrc <= pwdata[`SRCAF_CTRL_SRC_BIT];
            cfgFmt <= srcaf_fmt_t'(pwdata[`SRCAF_CTRL_FMT_LSB +: 2]);
            cfgCal <= pwdata[`SRCAF_CTRL_CAL_BIT];
         end
         if (paddr == `SRCAF_A_MASK) begin
            evMask <= pwdata[1:0];
         end
      end
   end

   // sticky events; a new event beats the clearing read
   assign evSet[`SRCAF_EV_RESYNC_BIT] = (state == HS_FLAG) & link.resyncPending;
   assign evSet[`SRCAF_EV_DONE_BIT]   = (state == HS_BUSYLO) & ~link.calBusy;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         evStatus <= 2'h0;
      end else if (ce) begin
         if (access && !pwrite && (paddr == `SRCAF_A_STATUS)) begin
            evStatus <= evSet;
         end else begin
            evStatus <= evStatus | evSet;
         end
      end
   end

   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (paddr)
         `SRCAF_A_CTRL:   rdMux = {25'h0, cfgCal, cfgFmt, cfgSrc, cfgDiv};
         `SRCAF_A_STATUS: rdMux = {30'h0, evStatus};
         `SRCAF_A_MASK:   rdMux = {30'h0, evMask};
         `SRCAF_A_STATE:  rdMux = {28'h0, link.portReady, link.calBusy, link.resyncPending, state != HS_IDLE};
         default:         rdMux = 32'h0000_0000;
      endcase
   end

   // read data captured in the setup cycle, held through the access
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         prdata  <= 32'h0000_0000;
         irq     <= 1'b0;
         playReg <= 16'h0000;
      end else if (ce) begin
         if (psel && !penable) begin
            prdata <= rdMux;
         end
         irq     <= |((evStatus | evSet) & evMask);
         playReg <= playSample;
      end
   end

   // divider and source go out together with the window bit
   assign link.ctrlValid   = (state == HS_ENTER) | (state == HS_EXIT);
   assign link.ctrlMce     = mceWord;
   assign link.ctrlFmtWr   = mceWord;
   assign link.ctrlDiv     = cfgDiv;
   assign link.ctrlSrc     = cfgSrc;
   assign link.ctrlFmt     = cfgFmt;
   assign link.ctrlCalExit = cfgCal;
   assign link.hostMute    = muteReg;
   assign link.playData    = playReg;
endmodule

//--- core/srcaf_link_if.sv
// serial-port link between the codec end and the host end
`timescale 1ns/100ps
`include "srcaf_map.svh"
interface srcaf_link_if;
   logic                  ctrlValid;     // control word offered
   logic                  ctrlMce;       // mode_change_window_bit
   logic                  ctrlFmtWr;     // word carries a data format write
   logic [2:0]            ctrlDiv;       // clock_divide_select
   logic                  ctrlSrc;       // clock_source_select
   srcaf_pkg::srcaf_fmt_t ctrlFmt;       // sample coding
   logic                  ctrlCalExit;   // calibrate_on_exit_bit
   logic                  hostMute;      // host mutes the outputs
   logic [15:0]           playData;      // playback sample
   logic                  portReady;     // port takes control words
   logic                  frameSync;     // frame start pulse
   logic                  sampleTick;    // capture sample valid pulse
   logic                  resyncPending; // status: port disabled for resync
   logic                  calBusy;       // status: calibration_busy_flag
   logic [15:0]           capData;       // coded capture sample
   modport device (
      input  ctrlValid, ctrlMce, ctrlFmtWr, ctrlDiv, ctrlSrc, ctrlFmt, ctrlCalExit, hostMute, playData,
      output portReady, frameSync, sampleTick, resyncPending, calBusy, capData
   );
   modport host (
      output ctrlValid, ctrlMce, ctrlFmtWr, ctrlDiv, ctrlSrc, ctrlFmt, ctrlCalExit, hostMute, playData,
      input  portReady, frameSync, sampleTick, resyncPending, calBusy, capData
   );
endinterface

//--- core/srcaf_map.svh
// constants for the rate-change codec pair: offsets, fields, resets, timing
`ifndef SRCAF_MAP_SVH
`define SRCAF_MAP_SVH
`define SRCAF_CLK_HZ          25000000
`define SRCAF_RESYNC_FIRST_MS 170
`define SRCAF_RESYNC_LATER_MS 5
`define SRCAF_RESYNC_FIRST_CYC (`SRCAF_RESYNC_FIRST_MS * (`SRCAF_CLK_HZ / 1000))
`define SRCAF_RESYNC_LATER_CYC (`SRCAF_RESYNC_LATER_MS * (`SRCAF_CLK_HZ / 1000))
`define SRCAF_TMO_W           23
`define SRCAF_CAL_SAMPLES     9'h180
`define SRCAF_MUTE_SAMPLES    9'h080
`define SRCAF_SAMPLE_BASE_CYC 10'h040
`define SRCAF_FIRST_SCLK_HZ   24'hBB_8000
`define SRCAF_SECOND_SCLK_HZ  24'hAC_4400
`define SRCAF_FMT_S16         2'h0
`define SRCAF_FMT_U8          2'h1
`define SRCAF_FMT_MU          2'h2
`define SRCAF_FMT_A           2'h3
`define SRCAF_SRC_FIRST       1'h0
`define SRCAF_DIV_RST         3'h0
`define SRCAF_CAL_RST         1'h0
`define SRCAF_MU_CLIP         16'h7F7B
`define SRCAF_MU_BIAS         16'h0084
`define SRCAF_A_POS_MASK      8'hD5
`define SRCAF_A_NEG_MASK      8'h55
`define SRCAF_A_CTRL          8'h00
`define SRCAF_A_STATUS        8'h04
`define SRCAF_A_MASK          8'h08
`define SRCAF_A_STATE         8'h0C
`define SRCAF_CTRL_DIV_LSB    0
`define SRCAF_CTRL_SRC_BIT    3
`define SRCAF_CTRL_FMT_LSB    4
`define SRCAF_CTRL_CAL_BIT    6
`define SRCAF_CTRL_GO_BIT     8
`define SRCAF_EV_RESYNC_BIT   0
`define SRCAF_EV_DONE_BIT     1
`endif

//--- core/srcaf_pkg.sv
// types shared by both ends of the rate-change codec link
`include "srcaf_map.svh"
package srcaf_pkg;
   typedef enum logic [1:0] {
      FMT_S16 = `SRCAF_FMT_S16,
      FMT_U8  = `SRCAF_FMT_U8,
      FMT_MU  = `SRCAF_FMT_MU,
      FMT_A   = `SRCAF_FMT_A
   } srcaf_fmt_t;
   typedef enum {DS_RUN, DS_ARMED, DS_NEXT, DS_RESYNC, DS_WAITFS} srcaf_dev_st_t;
   typedef enum {HS_IDLE, HS_ENTER, HS_FLAG, HS_PORT, HS_EXIT, HS_BUSYHI, HS_BUSYLO} srcaf_host_st_t;
endpackage

//--- testbench/srcaf_chk.sv
// concurrent checks on the link between the two codec ends
`timescale 1ns/100ps
module srcaf_chk (
   input wire logic clock,         // 25 MHz clock
   input wire logic rst_b,         // reset, active low
   input wire logic ctrlValid,     // control word offered
   input wire logic ctrlMce,       // mode_change_window_bit
   input wire logic portReady,     // port takes words
   input wire logic frameSync,     // frame start pulse
   input wire logic sampleTick,    // capture sample pulse
   input wire logic resyncPending, // port stopped for resync
   input wire logic calBusy        // calibration_busy_flag
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   // the port refuses words exactly while the resync flag stands
   ready_tracks_flag_a: assert property (portReady == !resyncPending)
      else $error("port ready disagrees with resync flag");
   no_sync_resync_a: assert property (resyncPending |-> !frameSync)
      else $error("frame sync during resync");
   sync_pulse_a: assert property (frameSync |=> !frameSync)
      else $error("frame sync wider than one cycle");
   resume_at_sync_a: assert property ($fell(resyncPending) |-> frameSync)
      else $error("port resumed without frame sync");
   tick_pulse_a: assert property (sampleTick |=> !sampleTick)
      else $error("sample tick wider than one cycle");
   busy_cause_a: assert property ($rose(calBusy) |-> $past(ctrlValid && portReady && !ctrlMce))
      else $error("busy rose without a window exit");
   // timeouts are many cycles even with the shortened parameters
   resync_holds_a: assert property ($rose(resyncPending) |=> resyncPending[*8])
      else $error("resync flag dropped early");
   busy_holds_a: assert property ($rose(calBusy) |=> calBusy[*8])
      else $error("busy flag dropped early");
   cov_resync: cover property ($rose(resyncPending));
   cov_busy: cover property ($rose(calBusy));
   cov_done: cover property ($fell(calBusy));
endmodule

//--- testbench/test_sample_rate_change_and_formats.sv
// self-checking bench for the rate-change codec pair
`timescale 1ns/100ps
module test_sample_rate_change_and_formats;
   import srcaf_pkg::*;
   logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, irq, outMuted, fce, sce, seenErr;
   logic        mutedBad = 1'b0, prevBusy = 1'b0, sr, psr;
   logic [2:0]  dv, pdv;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] adc, play, dac, lfsr;
   logic [23:0] hz;
   srcaf_fmt_t  fmt;
   int          failures, tests_run, cyc, busyCyc, b0, per, i;
   srcaf_link_if link();
   srcaf_device #(.RESYNC_FIRST_CYC(40), .RESYNC_LATER_CYC(20)) srcaf_device_inst (.clock(clock), .rst_b(rst_b),
      .ce(1'b1), .link(link), .adcSample(adc), .dacSample(dac), .outMuted(outMuted), .firstCrystalEn(fce),
      .secondCrystalEn(sce), .serialClockHz(hz), .activeFormat(fmt));
   srcaf_host srcaf_host_inst (.clock(clock), .rst_b(rst_b), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .link(link), .playSample(play));
   srcaf_chk srcaf_chk_inst (.clock(clock), .rst_b(rst_b), .ctrlValid(link.ctrlValid), .ctrlMce(link.ctrlMce),
      .portReady(link.portReady), .frameSync(link.frameSync), .sampleTick(link.sampleTick),
      .resyncPending(link.resyncPending), .calBusy(link.calBusy));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // busy length and output mute are watched beside the register traffic
   always @(posedge clock) begin
      cyc++;
      busyCyc += link.calBusy;
      if (prevBusy && link.calBusy && outMuted !== 1'b1) mutedBad <= 1'b1;
      prevBusy <= link.calBusy;
      // ceiling well above the roughly 60k cycles that the four sequences need
      if (cyc == 90000) begin
         failures++;
         conclude();
      end
   end
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      seenErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // expected capture code; companders follow the usual table-free forms
   function automatic logic [15:0] enc(input logic [1:0] f, input logic [15:0] x);
      logic [15:0] m;
      logic [3:0]  e;
      if (f == 2'h0) return x;
      if (f == 2'h1) return {8'h00, ~x[15], x[14:8]};
      if (f == 2'h2) begin
         m = x[15] ? -x : x;
         if (m > 16'h7F7B) m = 16'h7F7B;
         m = m + 16'h0084;
         e = 4'h7;
         while (e > 0 && !m[e + 7]) e--;
         return {8'h00, ~{x[15], e[2:0], 4'(m >> (e + 3))}};
      end
      m = 16'($signed(x) >>> 3);
      if (x[15]) m = ~m;
      e = 4'h0;
      while (e < 7 && m >= (16'h0020 << e)) e++;
      return {8'h00, {e[2:0], 4'(e < 2 ? m >> 1 : m >> e)} ^ (x[15] ? 8'h55 : 8'hD5)};
   endfunction
   initial begin
      {rst_b, psel, penable, pwrite, pdv, psr} = '0;
      {paddr, pwdata, failures, tests_run} = '0;
      lfsr = 16'h003E;
      adc = 16'h8000;
      play = 16'h1234;
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk("state", 32'h0000_0008, rd);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("ctrl", 32'h0000_0000, rd);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk("slverr", 32'h0000_0001, seenErr);
      // one rate-change sequence per coding; only the last runs the long calibration
      for (i = 0; i < 4; i++) begin
         lfsr = nxt(lfsr);
         // corner cases: no change, divider only, divider and source, no change
         dv = {2'h0, i == 1};
         sr = i >= 2;
         // high bits toggled so the companders reach their top segments
         if (i != 0) adc <= lfsr ^ 16'h6A00;
         play <= ~lfsr;
         apb(1'b1, 8'h08, (i == 0) ? 32'h0000_0000 : 32'h0000_0003);
         b0 = busyCyc;
         apb(1'b1, 8'h00, {23'h0, 1'b1, 1'b0, i == 3, 2'(i), sr, dv});
         do apb(1'b0, 8'h0C, 32'h0000_0000); while (rd[0] !== 1'b0);
         per = 64 * (dv + 1);
         b0 = busyCyc - b0 - ((i == 3) ? 384 : 128) * per;
         chk("busy length", 32'h0000_0001, b0 >= -per && b0 <= per);
         chk("irq", i != 0, irq);
         apb(1'b0, 8'h04, 32'h0000_0000);
         chk("status", {30'h0, 1'b1, dv != pdv || sr != psr}, rd);
         apb(1'b0, 8'h04, 32'h0000_0000);
         chk("status cleared", 32'h0000_0000, rd);
         chk("sclk rate", sr ? 24'hAC_4400 : 24'hBB_8000, hz);
         chk("crystal", {~sr, sr}, {fce, sce});
         chk("format", i, fmt);
         do @(posedge clock); while (link.sampleTick !== 1'b1);
         chk("capture code", enc(2'(i), adc), link.capData);
         chk("playback", play, dac);
         chk("output mute", 32'h0000_0000, outMuted);
         pdv = dv;
         psr = sr;
      end
      chk("mute in busy", 32'h0000_0000, mutedBad);
      conclude();
   end
endmodule
